/* verification/ep0_host_model.sv */
// Serial engine model that turns host traffic into one-cycle events.
`timescale 1ns/100ps
module ep0_host_model
(
	input wire logic clk_i,
	input wire logic ready_i,
	input wire logic busy_i,
	output ep0_ctrl_pkg::engine_event_type event_o
);
	// Pulse fields of the current event; levels come from the bench.
	ep0_ctrl_pkg::engine_event_type pend_q = '0;
	// Merge pulses and levels.
	always_comb
	begin
		event_o = pend_q;
		event_o.engine_ready = ready_i;
		event_o.fifo_busy = busy_i;
	end
	// One event for one cycle, then a quiet cycle; the setup stage starts with a token.
	task send(input ep0_ctrl_pkg::engine_event_type e);
		pend_q <= e;
		@(posedge clk_i);
		pend_q <= '0;
		@(posedge clk_i);
	endtask : send
endmodule : ep0_host_model

/* verification/ep0_transfer_ctrl_asserts.sv */
// Port-level checks for the endpoint zero transfer control block.
`timescale 1ns/100ps
module ep0_transfer_ctrl_asserts
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire ep0_ctrl_pkg::engine_event_type event_i,
	input wire ep0_ctrl_pkg::reply_type reply_o,
	input wire logic reply_valid_o,
	input wire logic flush_cpu_o,
	input wire logic flush_engine_o
);
	// ==========================================================================
	// Helper logic
	// ==========================================================================
	// Control register read and flush write seen this cycle.
	logic ctrl_rd;
	logic flush_wr;
	// A token or flush write one cycle back.
	logic token_q;
	logic flush_req_q;
	assign ctrl_rd = rd_i && addr_i == ep0_ctrl_pkg::ADDR_XFER_CTRL;
	assign flush_wr = wr_i && addr_i == ep0_ctrl_pkg::ADDR_XFER_CTRL
		&& wdata_i[ep0_ctrl_pkg::FLUSH_BIT];
	// Remember the causes so that each answer can be tied to one.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			token_q <= 1'b0;
			flush_req_q <= 1'b0;
		end
		else
		begin
			token_q <= event_i.setup_token || event_i.data_token || event_i.status_token;
			flush_req_q <= flush_wr;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// ==========================================================================
	// Assertions
	// ==========================================================================
	setup_ack_a: assert property (event_i.setup_token
		|=> reply_valid_o && reply_o == ep0_ctrl_pkg::REPLY_ACK) else $error("Setup not acked.");
	setup_nak_a: assert property (event_i.setup_token ##1 !wr_i ##1
		(event_i.data_token && !wr_i && !event_i.auto_request && !event_i.seq_code_valid)
		|=> reply_o == ep0_ctrl_pkg::REPLY_NAK) else $error("No NAK after setup.");
	error_stall_a: assert property (event_i.seq_code_valid && !event_i.auto_request &&
		event_i.seq_code == ep0_ctrl_pkg::SEQ_ERROR ##1 !wr_i ##1 (event_i.data_token && !wr_i)
		|=> reply_o == ep0_ctrl_pkg::REPLY_STALL) else $error("No stall after error.");
	auto_status_a: assert property (event_i.auto_request && !event_i.seq_code_valid
		##1 !wr_i ##1 (event_i.status_token && !wr_i) |=> reply_valid_o
		&& reply_o inside {ep0_ctrl_pkg::REPLY_ACK, ep0_ctrl_pkg::REPLY_DATA})
		else $error("Status not completed.");
	reply_cause_a: assert property (reply_valid_o |-> token_q)
		else $error("Reply without token.");
	flush_cause_a: assert property (flush_cpu_o || flush_engine_o |-> flush_req_q)
		else $error("Flush pulse without write.");
	busy_bit_a: assert property (ctrl_rd |=> rdata_o[11] == $past(event_i.fifo_busy)
		&& !rdata_o[12] && !rdata_o[9]) else $error("Control image wrong.");
	setup_clear_a: assert property (event_i.setup_token ##1 !wr_i ##1 (ctrl_rd
		&& !event_i.auto_request && !event_i.seq_code_valid) |=> rdata_o[15:14] == 2'h0
		&& !rdata_o[10]) else $error("Setup left state.");
	busy_refuse_a: assert property (flush_wr && event_i.fifo_busy
		|=> !flush_cpu_o && !flush_engine_o) else $error("Flush while busy.");
	cover property (reply_valid_o && reply_o == ep0_ctrl_pkg::REPLY_STALL);
	cover property (reply_valid_o && reply_o == ep0_ctrl_pkg::REPLY_DATA);
	cover property (flush_cpu_o);
endmodule : ep0_transfer_ctrl_asserts

bind ep0_transfer_ctrl ep0_transfer_ctrl_asserts i_chk
(
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.event_i(event_i),
	.reply_o(reply_o),
	.reply_valid_o(reply_valid_o),
	.flush_cpu_o(flush_cpu_o),
	.flush_engine_o(flush_engine_o)
);

/* verification/ep0_transfer_ctrl_tb.sv */
// Self-checking bench for the endpoint zero transfer control block.
`timescale 1ns/100ps
module ep0_transfer_ctrl_tb;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic last_i = 1'b0;
	logic ready_i = 1'b1;
	logic busy_i = 1'b1;
	logic rd_seen_q = 1'b0;
	logic [31:0] lfsr_q = 32'h954d;
	logic [8:0] len = 9'h000;
	logic [15:0] rdata_o;
	logic reply_valid_o, reply_zlp_o, flush_cpu_o, flush_engine_o, send_short_o, cpu_owns_o;
	ep0_ctrl_pkg::engine_event_type event_i;
	ep0_ctrl_pkg::reply_type reply_o;
	// Expected read data and replies, oldest first.
	logic [15:0] rd_q[$];
	// Expected replies carry the zero-length flag above the one-hot answer.
	logic [4:0] rep_q[$];
	// Set by a scenario when the next noted reply must be a zero-length packet.
	logic zlp_next = 1'b0;
	int miscompares = 0;
	int check_count = 0;
	// Pulses seen on the buffer control outputs.
	int flushes = 0;
	int engine_n = 0;
	int short_n = 0;
	// Free-running bench clock, 4 ns period.
	initial forever #2 clk_i = ~clk_i;

	ep0_transfer_ctrl i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_i(event_i),
		.cpu_fill_done_i(1'b0), .cpu_read_last_i(last_i), .reply_o(reply_o),
		.reply_valid_o(reply_valid_o), .reply_zlp_o(reply_zlp_o), .flush_cpu_o(flush_cpu_o),
		.flush_engine_o(flush_engine_o), .send_short_o(send_short_o), .cpu_owns_o(cpu_owns_o));
	ep0_host_model i_host (.clk_i(clk_i), .ready_i(ready_i), .busy_i(busy_i), .event_o(event_i));

	// ==========================================================================
	// Tasks
	// ==========================================================================
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// Next value of the stimulus shift register.
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next
	// Bus cycles: one strobe cycle, then one idle cycle.
	task wr(input logic [7:0] a, input logic [15:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	task rd(input logic [7:0] a, input logic [15:0] exp);
		addr_i <= a;
		rd_i <= 1'b1;
		rd_q.push_back(exp);
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
	endtask : rd
	task rc(input logic [15:0] exp);
		rd(ep0_ctrl_pkg::ADDR_XFER_CTRL, exp);
	endtask : rc
	// Engine event: 0 setup, 1 data, 2 status, 3 auto, 4 error, 5 receive, else transmit.
	task tok(input int k, input ep0_ctrl_pkg::reply_type r);
		ep0_ctrl_pkg::engine_event_type e;
		e = '0;
		case (k)
			0: e.setup_token = 1'b1;
			1: e.data_token = 1'b1;
			2: e.status_token = 1'b1;
			3: e.auto_request = 1'b1;
			4: {e.seq_code_valid, e.seq_code} = {1'b1, ep0_ctrl_pkg::SEQ_ERROR};
			5: {e.rx_done, e.rx_len} = {1'b1, len};
			default: e.tx_done = 1'b1;
		endcase
		if (k < 3)
			rep_q.push_back({zlp_next, r});
		zlp_next = 1'b0;
		i_host.send(e);
	endtask : tok

	// Compare each answer with the oldest note and count the buffer control pulses.
	always @(posedge clk_i)
	begin : watch
		logic [15:0] r;
		if (rd_seen_q)
			chk("rdata", rd_q.pop_front(), rdata_o);
		if (reply_valid_o === 1'b1)
		begin
			r = rep_q.size() > 0 ? 16'(rep_q.pop_front()) : 16'hffff;
			chk("reply", r, 16'({reply_zlp_o, reply_o}));
		end
		if (flush_cpu_o === 1'b1)
			flushes++;
		if (flush_engine_o === 1'b1)
			engine_n++;
		if (send_short_o === 1'b1)
			short_n++;
		rd_seen_q <= rd_i;
	end

	// Watchdog: the scenarios need about 120 cycles, so 3000 means a hang.
	initial
	begin
		repeat (3000) @(posedge clk_i);
		miscompares++;
		report_and_stop();
	end

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	initial
	begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		rc(ep0_ctrl_pkg::XFER_CTRL_RESET);
		wr(ep0_ctrl_pkg::ADDR_XFER_CTRL, 16'h1000);
		busy_i <= 1'b0;
		rd(8'h3c, 16'h0000);
		wr(ep0_ctrl_pkg::ADDR_MODE, 16'h8002);
		tok(0, ep0_ctrl_pkg::REPLY_ACK);
		tok(1, ep0_ctrl_pkg::REPLY_NAK);
		tok(2, ep0_ctrl_pkg::REPLY_NAK);
		wr(ep0_ctrl_pkg::ADDR_XFER_CTRL, 16'h4000);
		rc(16'h4000);
		tok(1, ep0_ctrl_pkg::REPLY_ACK);
		ready_i <= 1'b0;
		tok(1, ep0_ctrl_pkg::REPLY_NAK);
		ready_i <= 1'b1;
		rd(ep0_ctrl_pkg::ADDR_FLAGS, 16'h0001);
		wr(ep0_ctrl_pkg::ADDR_FLAGS, 16'h000f);
		lfsr_q = lfsr_next(lfsr_q);
		len = {3'h0, lfsr_q[5:0]} + 9'h004;
		tok(5, ep0_ctrl_pkg::REPLY_NAK);
		rc({4'h6, 3'h0, len});
		chk("owner", 16'h0001, 16'(cpu_owns_o));
		rd(ep0_ctrl_pkg::ADDR_FLAGS, 16'h0002);
		wc_ignored: wr(ep0_ctrl_pkg::ADDR_XFER_CTRL, 16'h0000);
		rd(ep0_ctrl_pkg::ADDR_DATA, 16'h0000);
		rc({4'h6, 3'h0, len - 9'h001});
		wr(ep0_ctrl_pkg::ADDR_MODE, 16'h8000);
		rd(ep0_ctrl_pkg::ADDR_DATA, 16'h0000);
		rc({4'h6, 3'h0, len - 9'h003});
		wr(ep0_ctrl_pkg::ADDR_MODE, 16'h0000);
		rd(ep0_ctrl_pkg::ADDR_DATA, 16'h0000);
		rc({4'h6, 3'h0, len - 9'h003});
		last_i <= 1'b1;
		rd(ep0_ctrl_pkg::ADDR_DATA, 16'h0000);
		last_i <= 1'b0;
		rc(16'h4000);
		tok(5, ep0_ctrl_pkg::REPLY_NAK);
		wr(ep0_ctrl_pkg::ADDR_XFER_CTRL, 16'h1000);
		rc(16'h4000);
		chk("flush pulses", 16'h0001, 16'(flushes));
		wr(ep0_ctrl_pkg::ADDR_MODE, 16'h0005);
		wr(ep0_ctrl_pkg::ADDR_FLAGS, 16'h000f);
		wr(ep0_ctrl_pkg::ADDR_XFER_CTRL, 16'h6000);
		rc(16'h6000);
		chk("owner", 16'h0000, 16'(cpu_owns_o));
		tok(1, ep0_ctrl_pkg::REPLY_DATA);
		tok(6, ep0_ctrl_pkg::REPLY_NAK);
		rc(16'h4000);
		rd(ep0_ctrl_pkg::ADDR_FLAGS, 16'h0004);
		wr(ep0_ctrl_pkg::ADDR_XFER_CTRL, 16'h7000);
		zlp_next = 1'b1;
		tok(1, ep0_ctrl_pkg::REPLY_DATA);
		tok(6, ep0_ctrl_pkg::REPLY_NAK);
		rc(16'h4000);
		ready_i <= 1'b0;
		tok(1, ep0_ctrl_pkg::REPLY_NAK);
		ready_i <= 1'b1;
		wr(ep0_ctrl_pkg::ADDR_XFER_CTRL, 16'h2000);
		wr(ep0_ctrl_pkg::ADDR_XFER_CTRL, 16'h1000);
		rc(16'h0000);
		rd(ep0_ctrl_pkg::ADDR_FLAGS, 16'h000d);
		tok(4, ep0_ctrl_pkg::REPLY_NAK);
		tok(1, ep0_ctrl_pkg::REPLY_STALL);
		tok(2, ep0_ctrl_pkg::REPLY_STALL);
		tok(0, ep0_ctrl_pkg::REPLY_ACK);
		tok(3, ep0_ctrl_pkg::REPLY_NAK);
		tok(2, ep0_ctrl_pkg::REPLY_ACK);
		rc(16'h4400);
		wr(ep0_ctrl_pkg::ADDR_MODE, 16'h0000);
		zlp_next = 1'b1;
		tok(2, ep0_ctrl_pkg::REPLY_DATA);
		tok(0, ep0_ctrl_pkg::REPLY_ACK);
		rc(16'h0000);
		repeat (2) @(posedge clk_i);
		chk("replies left", 16'h0000, 16'(rep_q.size()));
		chk("pulse counts", 16'h0212, 16'({flushes[3:0], engine_n[3:0], short_n[3:0]}));
		report_and_stop();
	end
endmodule : ep0_transfer_ctrl_tb

/* verilog/ep0_ctrl_pkg.sv */
// Constants, field layouts and carrier types for the endpoint zero transfer control block.
package ep0_ctrl_pkg;

	// ==========================================================================
	// Register map
	// ==========================================================================
	// Byte address of the transfer control register.
	localparam logic [7:0] ADDR_XFER_CTRL = 8'h32;
	// Byte address of the mode register (direction, byte access, empty enable, countdown).
	localparam logic [7:0] ADDR_MODE = 8'h40;
	// Byte address of the data port (read lowers the count in countdown mode, write fills the buffer).
	localparam logic [7:0] ADDR_DATA = 8'h34;
	// Byte address of the event flag register (write one to clear).
	localparam logic [7:0] ADDR_FLAGS = 8'h38;

	// ==========================================================================
	// Transfer control register fields
	// ==========================================================================
	localparam int SEL_HI = 15;
	localparam int SEL_LO = 14;
	localparam int VALID_BIT = 13;
	localparam int FLUSH_BIT = 12;
	localparam int NOT_READY_BIT = 11;
	localparam int COMPLETION_BIT = 10;
	localparam int COUNT_W = 9;
	// Value of the register after reset: only the not-ready bit is set.
	localparam logic [15:0] XFER_CTRL_RESET = 16'h0800;

	// ==========================================================================
	// Mode register fields
	// ==========================================================================
	localparam int MODE_DIR_BIT = 0;
	localparam int MODE_BYTE_BIT = 1;
	localparam int MODE_EMPE_BIT = 2;
	localparam int MODE_CNTDN_BIT = 15;

	// ==========================================================================
	// Flag register fields
	// ==========================================================================
	localparam int FLAG_NRD_BIT = 0;
	localparam int FLAG_RDY_BIT = 1;
	localparam int FLAG_EMPOVR_BIT = 2;
	localparam int FLAG_EMPTY_BIT = 3;

	// Selector encodings.
	localparam logic [1:0] SEL_NAK = 2'h0;
	localparam logic [1:0] SEL_BUF = 2'h1;
	localparam logic [1:0] SEL_STALL = 2'h2;
	// Stage sequence code that reports a sequence error.
	localparam logic [2:0] SEQ_ERROR = 3'h6;
	// Count steps for byte and word access.
	localparam logic [8:0] STEP_BYTE = 9'h001;
	localparam logic [8:0] STEP_WORD = 9'h002;

	// Handshake answer to the serial engine.
	typedef enum logic [3:0]
	{
		REPLY_ACK = 4'b0001,
		REPLY_NAK = 4'b0010,
		REPLY_STALL = 4'b0100,
		REPLY_DATA = 4'b1000
	} reply_type;

	// Events reported by the serial engine; one-cycle pulses except the engine_ready and fifo_busy levels.
	typedef struct packed
	{
		logic setup_token;
		logic auto_request;
		logic seq_code_valid;
		logic [2:0] seq_code;
		logic data_token;
		logic status_token;
		logic packet_busy;
		logic rx_done;
		logic [8:0] rx_len;
		logic tx_done;
		logic engine_ready;
		logic fifo_busy;
	} engine_event_type;

	// Whole state of the block.
	typedef struct packed
	{
		logic [1:0] selector;
		logic valid;
		logic completion;
		logic [8:0] count;
		logic direction;
		logic byte_mode;
		logic empty_enable;
		logic countdown;
		logic zlp_pending;
		logic nrd;
		logic rdy;
		logic empovr;
		logic empty_irq;
		logic [15:0] rdata;
		logic [3:0] reply;
		logic reply_valid;
		logic flush_cpu;
		logic flush_engine;
		logic send_short;
	} state_type;

endpackage : ep0_ctrl_pkg

/* verilog/ep0_transfer_ctrl.sv */
// Endpoint zero control transfer handshake, buffer ownership and count logic.
`timescale 1ns/100ps
// What this block does
// [RULE1] Selector 00 answers NAK in data, status.
// [RULE2] Setup stage always acknowledged regardless of selector.
// [RULE3] Selector writes ignored while buffer valid set.
// [RULE4] Write direction: ACK if ready, else NAK+flag.
// [RULE5] Read direction: send if ready, else NAK+flag.
// [RULE6] Selector upper bit set answers STALL.
// [RULE7] Packet in progress finishes; new selector next.
// [RULE8] Hardware loads selector on setup, auto, error.
// [RULE9] Auto request sets status completion, sends ZLP in write direction.
// [RULE10] Buffer valid meaningful only when not-ready low.
// [RULE11] Write: valid sets on receive, clears on read/flush.
// [RULE12] Read: valid clears on transmit/flush; empty error.
// [RULE13] Read: valid sets on fill or forced write.
// [RULE14] Valid plus flush together sends zero-length packet.
// [RULE15] Write flush clears buffer, valid, count; self-clears.
// [RULE16] Read flush: clears CPU or engine buffer.
// [RULE17] Flush with transmit data raises buffer-empty event.
// [RULE18] Software waits for not-ready low before access.
// [RULE19] Status completion decides status-stage ZLP, ACK, NAK.
// [RULE20] Setup token clears status completion bit.
// [RULE21] Nine-bit count shows received bytes, counts down.
// [RULE22] Countdown mode: minus one/two, else clear at end.
// [RULE23] Direction bit picks write or read buffer.
// [RULE24] Self-set fields update same cycle; engine wins.
module ep0_transfer_ctrl
(
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Serial engine events.
	input wire ep0_ctrl_pkg::engine_event_type event_i,
	// CPU buffer reports that the transmit data has been written completely.
	input wire logic cpu_fill_done_i,
	// CPU buffer reports that the last received byte or word has been read.
	input wire logic cpu_read_last_i,
	// Handshake answer to the serial engine.
	output ep0_ctrl_pkg::reply_type reply_o,
	output logic reply_valid_o,
	// Answer is a zero-length packet.
	output logic reply_zlp_o,
	// Buffer control pulses.
	output logic flush_cpu_o,
	output logic flush_engine_o,
	output logic send_short_o,
	// Buffer ownership: high while the CPU owns the buffer.
	output logic cpu_owns_o
);

	// ==========================================================================
	// State
	// ==========================================================================
	ep0_ctrl_pkg::state_type state_q; // Registered state.
	ep0_ctrl_pkg::state_type state_d; // Next state.
	logic [15:0] ctrl_word; // Assembled control register image.
	logic [15:0] mode_word; // Assembled mode register image.
	logic [3:0] flag_word; // Assembled flag register image.

	// Turn selector and context into a reply.
	function automatic ep0_ctrl_pkg::reply_type pick_reply(input logic [1:0] sel,
		input logic ready);
		ep0_ctrl_pkg::reply_type r;
		r = ep0_ctrl_pkg::REPLY_NAK;
		if (sel[1])
			r = ep0_ctrl_pkg::REPLY_STALL; // RULE6
		else if (sel == ep0_ctrl_pkg::SEL_BUF && ready)
			r = ep0_ctrl_pkg::REPLY_ACK;
		return r; // RULE1
	endfunction : pick_reply

	// Images of the readable registers.
	always_comb
	begin
		ctrl_word = {state_q.selector, state_q.valid, 1'b0, event_i.fifo_busy,
			state_q.completion, 1'b0, state_q.count};
		mode_word = 16'h0000;
		mode_word[ep0_ctrl_pkg::MODE_DIR_BIT] = state_q.direction;
		mode_word[ep0_ctrl_pkg::MODE_BYTE_BIT] = state_q.byte_mode;
		mode_word[ep0_ctrl_pkg::MODE_EMPE_BIT] = state_q.empty_enable;
		mode_word[ep0_ctrl_pkg::MODE_CNTDN_BIT] = state_q.countdown;
		flag_word = {state_q.empty_irq, state_q.empovr, state_q.rdy, state_q.nrd};
	end

	// ==========================================================================
	// Next state
	// ==========================================================================
	// Software writes are applied first, then engine events override them.
	always_comb
	begin
		logic wr_ctrl;
		logic wr_flags;
		logic flush;
		logic force_valid;
		logic ready;
		logic [8:0] step;
		wr_ctrl = wr_i && addr_i == ep0_ctrl_pkg::ADDR_XFER_CTRL;
		wr_flags = wr_i && addr_i == ep0_ctrl_pkg::ADDR_FLAGS;
		flush = wr_ctrl && wdata_i[ep0_ctrl_pkg::FLUSH_BIT];
		force_valid = wr_ctrl && wdata_i[ep0_ctrl_pkg::VALID_BIT];
		ready = 1'b0;
		step = state_q.byte_mode ? ep0_ctrl_pkg::STEP_BYTE : ep0_ctrl_pkg::STEP_WORD;
		state_d = state_q;
		state_d.reply_valid = 1'b0;
		state_d.flush_cpu = 1'b0;
		state_d.flush_engine = 1'b0;
		state_d.send_short = 1'b0;

		// Register reads return data one cycle later.
		state_d.rdata = 16'h0000;
		if (rd_i)
		begin
			case (addr_i)
				ep0_ctrl_pkg::ADDR_XFER_CTRL: state_d.rdata = ctrl_word;
				ep0_ctrl_pkg::ADDR_MODE: state_d.rdata = mode_word;
				ep0_ctrl_pkg::ADDR_FLAGS: state_d.rdata = {12'h000, flag_word};
				default: state_d.rdata = 16'h0000;
			endcase
		end

		// Mode register write.
		if (wr_i && addr_i == ep0_ctrl_pkg::ADDR_MODE)
		begin
			state_d.direction = wdata_i[ep0_ctrl_pkg::MODE_DIR_BIT]; // RULE23
			state_d.byte_mode = wdata_i[ep0_ctrl_pkg::MODE_BYTE_BIT];
			state_d.empty_enable = wdata_i[ep0_ctrl_pkg::MODE_EMPE_BIT];
			state_d.countdown = wdata_i[ep0_ctrl_pkg::MODE_CNTDN_BIT];
		end

		// Flag clears by writing one.
		if (wr_flags)
		begin
			if (wdata_i[ep0_ctrl_pkg::FLAG_NRD_BIT])
				state_d.nrd = 1'b0;
			if (wdata_i[ep0_ctrl_pkg::FLAG_RDY_BIT])
				state_d.rdy = 1'b0;
			if (wdata_i[ep0_ctrl_pkg::FLAG_EMPOVR_BIT])
				state_d.empovr = 1'b0;
			if (wdata_i[ep0_ctrl_pkg::FLAG_EMPTY_BIT])
				state_d.empty_irq = 1'b0;
		end

		// Control register write; valid and count only act when not busy.
		if (wr_ctrl)
		begin
			if (!state_q.valid)
				state_d.selector = wdata_i[ep0_ctrl_pkg::SEL_HI:ep0_ctrl_pkg::SEL_LO]; // RULE3
			state_d.completion = wdata_i[ep0_ctrl_pkg::COMPLETION_BIT];
		end
		if (!event_i.fifo_busy) // RULE10 RULE18
		begin
			if (!state_q.direction)
			begin
				// Write direction: flush discards received data.
				if (flush && state_q.valid)
				begin
					state_d.valid = 1'b0; // RULE15
					state_d.count = 9'h000;
					state_d.flush_cpu = 1'b1;
				end
				// Data port reads lower the count in countdown mode; the last read clears it.
				if (rd_i && addr_i == ep0_ctrl_pkg::ADDR_DATA && state_q.valid)
				begin
					if (state_q.countdown)
						state_d.count = (state_q.count > step) ? 9'(state_q.count - step)
							: 9'h000; // RULE22
					if (cpu_read_last_i)
					begin
						state_d.count = 9'h000; // RULE21
						state_d.valid = 1'b0; // RULE11
					end
				end
			end
			else
			begin
				// Read direction flush and forced valid.
				if (flush)
				begin
					if (state_q.valid)
					begin
						state_d.flush_engine = 1'b1; // RULE16
						state_d.valid = 1'b0;
						// Dropping a loaded buffer counts as an empty clear as well.
						if (state_q.empty_enable)
							state_d.empovr = 1'b1; // RULE12
					end
					else
						state_d.flush_cpu = 1'b1;
					state_d.empty_irq = 1'b1; // RULE17
				end
				if (force_valid && !state_q.valid)
				begin
					state_d.valid = 1'b1; // RULE13
					state_d.send_short = !flush;
					state_d.zlp_pending = flush; // RULE14
				end
				if (cpu_fill_done_i && !state_q.valid)
					state_d.valid = 1'b1; // RULE13
			end
		end

		// Engine events override software in the same cycle.
		if (event_i.rx_done && !state_q.direction)
		begin
			state_d.valid = 1'b1; // RULE11 RULE24
			state_d.rdy = 1'b1;
			state_d.count = event_i.rx_len; // RULE21
		end
		if (event_i.tx_done && state_q.direction && state_q.valid)
		begin
			state_d.valid = 1'b0; // RULE12
			state_d.zlp_pending = 1'b0; // RULE14
			if (state_q.empty_enable)
				state_d.empovr = 1'b1;
		end

		// Token handling.
		if (event_i.setup_token)
		begin
			state_d.reply = ep0_ctrl_pkg::REPLY_ACK; // RULE2
			state_d.reply_valid = 1'b1;
			state_d.selector = ep0_ctrl_pkg::SEL_NAK; // RULE8
			state_d.completion = 1'b0; // RULE20
		end
		else if (event_i.data_token)
		begin
			ready = event_i.engine_ready;
			// A transaction in flight keeps its answer; selector counts next time.
			state_d.reply = ep0_ctrl_pkg::reply_type'(
				event_i.packet_busy ? state_q.reply : pick_reply(state_q.selector, ready)); // RULE7
			if (!event_i.packet_busy && state_q.direction
				&& state_d.reply == ep0_ctrl_pkg::REPLY_ACK)
				state_d.reply = ep0_ctrl_pkg::REPLY_DATA; // RULE5
			if (state_q.selector == ep0_ctrl_pkg::SEL_BUF && !ready)
				state_d.nrd = 1'b1; // RULE4 RULE5
			state_d.reply_valid = 1'b1;
		end
		else if (event_i.status_token)
		begin
			// Status stage follows the completion bit.
			state_d.reply = pick_reply(state_q.selector, state_q.completion); // RULE19
			// An IN status token cannot be acked: a write transfer sends an empty packet.
			if (!state_q.direction && state_d.reply == ep0_ctrl_pkg::REPLY_ACK)
				state_d.reply = ep0_ctrl_pkg::REPLY_DATA; // RULE9 RULE19
			state_d.reply_valid = 1'b1;
		end
		if (event_i.auto_request)
		begin
			state_d.selector = ep0_ctrl_pkg::SEL_BUF; // RULE8
			state_d.completion = 1'b1; // RULE9
		end
		if (event_i.seq_code_valid && event_i.seq_code == ep0_ctrl_pkg::SEQ_ERROR)
			state_d.selector = ep0_ctrl_pkg::SEL_STALL; // RULE8
	end

	// ==========================================================================
	// State register
	// ==========================================================================
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_q <= '0;
			state_q.reply <= ep0_ctrl_pkg::REPLY_NAK;
		end
		else
			state_q <= state_d;
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign rdata_o = state_q.rdata;
	assign reply_o = ep0_ctrl_pkg::reply_type'(state_q.reply);
	assign reply_valid_o = state_q.reply_valid;
	// A status answer of data while the completion bit is set, or a forced empty send.
	// Only a data answer can be empty, so handshakes never carry the flag.
	assign reply_zlp_o = state_q.reply_valid && state_q.reply == ep0_ctrl_pkg::REPLY_DATA
		&& (state_q.zlp_pending || (state_q.completion && !state_q.direction)); // RULE9 RULE14
	assign flush_cpu_o = state_q.flush_cpu;
	assign flush_engine_o = state_q.flush_engine;
	assign send_short_o = state_q.send_short;
	assign cpu_owns_o = state_q.direction ? !state_q.valid : state_q.valid;

endmodule : ep0_transfer_ctrl
